// ---- verilog/irrd_pkg.sv ----
// Package: opcode patterns, field positions and carriers for the decoder
package irrd_pkg;

  // ==========================================================================
  // Instruction word layout
  localparam int unsigned INSTR_W    = 14;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FADDR_W    = 7;
  localparam int unsigned PC_W       = 13;
  localparam int unsigned DEST_BIT   = 7;
  localparam int unsigned OPC6_HI    = 13;
  localparam int unsigned OPC6_LO    = 8;
  localparam int unsigned OPC4_LO    = 10;
  localparam int unsigned STACK_DEPTH = 8;

  // ==========================================================================
  // Opcode patterns
  localparam logic [5:0]         OPC_INC      = 6'h0A;
  localparam logic [5:0]         OPC_INC_SKIP = 6'h0F;
  localparam logic [5:0]         OPC_ROTATE   = 6'h0D;
  localparam logic [3:0]         OPC_LIT_RET  = 4'hD;
  localparam logic [INSTR_W-1:0] OPC_RETURN   = 14'h0008;

  // ==========================================================================
  // Reset values and arithmetic constants
  localparam logic [DATA_W-1:0] W_RST   = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST  = 13'h0000;
  localparam logic [DATA_W-1:0] ONE_B   = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_B  = 8'h00;
  localparam logic [PC_W-1:0]   PC_ONE  = 13'h0001;
  localparam logic [PC_W-1:0]   PC_TWO  = 13'h0002;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_INC,
    OP_INC_SKIP,
    OP_ROTATE,
    OP_LIT_RET,
    OP_RETURN
  } irrd_op_t;

  typedef struct packed {
    logic               we;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } irrd_file_wr_t;

endpackage

// ---- verilog/irrd_alu.sv ----
// Arithmetic for increment and rotate-through-carry
`timescale 1ns/1ps
module irrd_alu
  import irrd_pkg::*;
(
  input  wire irrd_op_t          i_op,     // Decoded operation
  input  wire logic [DATA_W-1:0] i_src,    // File register operand
  input  wire logic              i_carry,  // Current carry flag
  output logic      [DATA_W-1:0] o_res,    // Result
  output logic                   o_carry,  // Carry after the operation
  output logic                   o_zero    // Result equals zero
);

  always_comb begin
    o_res   = i_src;
    o_carry = i_carry;
    case (i_op)
      OP_INC, OP_INC_SKIP: begin
        o_res = i_src + ONE_B;
      end
      OP_ROTATE: begin
        o_res   = {i_src[DATA_W-2:0], i_carry};
        o_carry = i_src[DATA_W-1];
      end
      default: begin
        o_res = i_src;
      end
    endcase
    o_zero = (o_res == ZERO_B);
  end

endmodule

// ---- verilog/irrd_core.sv ----
// Decoder and executor for increment, skip, rotate and return instructions
// ============================================================================
`timescale 1ns/1ps
module irrd_core
  import irrd_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH
)(
  input  wire logic               i_mclk,        // Instruction clock
  input  wire logic               i_rst_b,       // Asynchronous reset, active low
  input  wire logic               i_instr_valid, // Fetched word present
  input  wire logic [INSTR_W-1:0] i_instr,       // Fetched instruction word
  input  wire logic [DATA_W-1:0]  i_file_data,   // Contents of addressed file register
  input  wire logic               i_call_push,   // Push a return address
  input  wire logic [PC_W-1:0]    i_call_addr,   // Return address to push
  output irrd_file_wr_t           o_file_wr,     // File register write
  output logic      [DATA_W-1:0]  o_w,           // Accumulator
  output logic                    o_zero,        // Zero flag
  output logic                    o_carry,       // Carry flag
  output logic      [PC_W-1:0]    o_pc,          // program_counter
  output logic                    o_bubble       // Current fetched word is discarded
);

  localparam int unsigned SP_W = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("DEPTH must be a power of two, at least 2");
    end
  end

  // ==========================================================================
  // Decode
  irrd_op_t           op;
  logic               exec;
  logic               dest_file;
  logic [FADDR_W-1:0] faddr;
  logic [DATA_W-1:0]  alu_res;
  logic               alu_carry;
  logic               alu_zero;

  assign exec      = i_instr_valid && !o_bubble;
  assign dest_file = i_instr[DEST_BIT];
  assign faddr     = i_instr[FADDR_W-1:0];

  always_comb begin
    op = OP_NONE;
    if (i_instr == OPC_RETURN) begin
      op = OP_RETURN;
    end else if (i_instr[OPC6_HI:OPC4_LO] == OPC_LIT_RET) begin
      op = OP_LIT_RET;
    end else begin
      case (i_instr[OPC6_HI:OPC6_LO])
        OPC_INC:      op = OP_INC;
        OPC_INC_SKIP: op = OP_INC_SKIP;
        OPC_ROTATE:   op = OP_ROTATE;
        default:      op = OP_NONE;
      endcase
    end
  end

  irrd_alu u_alu (
    .i_op    (op),
    .i_src   (i_file_data),
    .i_carry (o_carry),
    .o_res   (alu_res),
    .o_carry (alu_carry),
    .o_zero  (alu_zero)
  );

  // ==========================================================================
  // Return stack (circular, wraps silently like the hardware stack)
  logic [PC_W-1:0] stack_mem [DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [PC_W-1:0] stack_head;
  logic            pop;

  assign stack_head = stack_mem[sp_r - SP_W'(1)];
  assign pop        = exec && (op == OP_LIT_RET || op == OP_RETURN);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sp_r <= '0;
    end else if (pop) begin
      sp_r <= sp_r - SP_W'(1);
    end else if (i_call_push) begin
      sp_r <= sp_r + SP_W'(1);
    end
  end

  // Storage has no reset; an empty stack simply returns stale addresses
  always_ff @(posedge i_mclk) begin
    if (i_call_push && !pop) begin
      stack_mem[sp_r] <= i_call_addr;
    end
  end

  // ==========================================================================
  // Destination routing
  logic is_alu_op;
  assign is_alu_op = (op == OP_INC) || (op == OP_INC_SKIP) || (op == OP_ROTATE);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_file_wr <= '0;
    end else begin
      o_file_wr.we   <= exec && is_alu_op && dest_file;
      o_file_wr.addr <= faddr;
      o_file_wr.data <= alu_res;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_w <= W_RST;
    end else if (exec && is_alu_op && !dest_file) begin
      o_w <= alu_res;
    end else if (exec && op == OP_LIT_RET) begin
      o_w <= i_instr[DATA_W-1:0];
    end
  end

  // ==========================================================================
  // Status flags; skip and return forms leave both untouched
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_zero  <= 1'b0;
      o_carry <= 1'b0;
    end else if (exec) begin
      if (op == OP_INC) begin
        o_zero <= alu_zero;
      end
      if (op == OP_ROTATE) begin
        o_carry <= alu_carry;
      end
    end
  end

  // ==========================================================================
  // Program flow; a bubble cycle refills the pipe and holds the PC
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pc     <= PC_RST;
      o_bubble <= 1'b0;
    end else begin
      o_bubble <= 1'b0;
      if (exec) begin
        o_pc <= o_pc + PC_ONE;
        if (pop) begin
          o_pc     <= stack_head;
          o_bubble <= 1'b1;
        end else if (op == OP_INC_SKIP && alu_zero) begin
          o_pc     <= o_pc + PC_TWO;
          o_bubble <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  a_inc_to_file: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    exec && op == OP_INC && dest_file |=>
      o_file_wr.we && o_file_wr.data == $past(i_file_data) + ONE_B
      && o_zero == ($past(i_file_data) == 8'hFF))
    else $error("increment to file wrong");

  a_dest_accum: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    exec && is_alu_op && !dest_file |=> !o_file_wr.we && o_w == $past(alu_res))
    else $error("accumulator destination wrong");

  a_skip_flags_kept: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    exec && op == OP_INC_SKIP |=> $stable(o_zero) && $stable(o_carry))
    else $error("skip increment touched flags");

  // Back-to-back skips are legal, so the bubble is judged only one cycle out
  a_skip_bubble: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    exec && op == OP_INC_SKIP |=>
      o_bubble == ($past(i_file_data) == 8'hFF)
      && o_pc == $past(o_pc) + (o_bubble ? PC_TWO : PC_ONE))
    else $error("skip bubble wrong");

  a_bubble_single: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_bubble |=> !o_bubble && $stable(o_pc) && !o_file_wr.we)
    else $error("bubble cycle executed a word");

  a_lit_ret_load: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    exec && op == OP_LIT_RET |=>
      o_w == $past(i_instr[DATA_W-1:0]) && o_pc == $past(stack_head)
      && o_bubble && $stable(o_carry))
    else $error("literal return wrong");

  a_rotate_carry: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    exec && op == OP_ROTATE |=>
      o_carry == $past(i_file_data[DATA_W-1])
      && o_file_wr.data == {$past(i_file_data[DATA_W-2:0]), $past(o_carry)})
    else $error("rotate through carry wrong");

  a_return_pop: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    exec && op == OP_RETURN |=>
      o_pc == $past(stack_head) && o_bubble && $stable(o_zero)
      && sp_r == $past(sp_r) - SP_W'(1))
    else $error("return pop wrong");

  a_field_decode: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_instr_valid && !o_bubble && i_instr[OPC6_HI:OPC4_LO] == OPC_LIT_RET |-> op == OP_LIT_RET)
    else $error("literal return decode ignores wrong bits");

endmodule

// ---- testbench/tb_irrd_core.sv ----
// Self-checking bench for the increment, skip, rotate and return decoder
`timescale 1ns/1ps
module tb_irrd_core
  import irrd_pkg::*;
;
  // ==========================================================================
  // Signals and design instance
  logic               i_mclk;
  logic               i_rst_b;
  logic               i_instr_valid;
  logic [INSTR_W-1:0] i_instr;
  logic [DATA_W-1:0]  i_file_data;
  logic               i_call_push;
  logic [PC_W-1:0]    i_call_addr;
  irrd_file_wr_t      o_file_wr;
  logic [DATA_W-1:0]  o_w;
  logic               o_zero;
  logic               o_carry;
  logic [PC_W-1:0]    o_pc;
  logic               o_bubble;
  int                 n_fail;
  int                 samples_checked;

  irrd_core #(.DEPTH(8)) i_dut (
    .i_mclk        (i_mclk),
    .i_rst_b       (i_rst_b),
    .i_instr_valid (i_instr_valid),
    .i_instr       (i_instr),
    .i_file_data   (i_file_data),
    .i_call_push   (i_call_push),
    .i_call_addr   (i_call_addr),
    .o_file_wr     (o_file_wr),
    .o_w           (o_w),
    .o_zero        (o_zero),
    .o_carry       (o_carry),
    .o_pc          (o_pc),
    .o_bubble      (o_bubble)
  );

  initial i_mclk = 1'b0;
  always #5 i_mclk = ~i_mclk;

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Valid stays high between calls so back-to-back words reach the core
  task automatic exec(input logic [INSTR_W-1:0] ins, input logic [DATA_W-1:0] d);
    i_instr_valid = 1'b1;
    i_instr       = ins;
    i_file_data   = d;
    @(negedge i_mclk);
  endtask

  task automatic idle();
    i_instr_valid = 1'b0;
    @(negedge i_mclk);
  endtask

  // Push stays high so back-to-back pushes never drop and raise it in one step
  task automatic push(input logic [PC_W-1:0] a);
    i_call_push = 1'b1;
    i_call_addr = a;
    @(negedge i_mclk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    check("pc", o_pc, 16'h0000);
    check("w", o_w, 16'h0000);
    check("file_wr", o_file_wr, 16'h0000);
    check("flags", {o_zero, o_carry, o_bubble}, 16'h0000);
  endtask

  task automatic t_inc();
    exec(14'h0A95, 8'hFF);
    check("wr_we", o_file_wr.we, 16'h0001);
    check("wr_addr", o_file_wr.addr, 16'h0015);
    check("wr_data", o_file_wr.data, 16'h0000);
    check("zero", o_zero, 16'h0001);
    check("pc", o_pc, 16'h0001);
    exec(14'h0A23, 8'h41);
    check("wr_we", o_file_wr.we, 16'h0000);
    check("w", o_w, 16'h0042);
    check("zero", o_zero, 16'h0000);
    check("pc", o_pc, 16'h0002);
    idle();
  endtask

  task automatic t_skip();
    exec(14'h0F10, 8'h10);
    check("w", o_w, 16'h0011);
    check("bubble", o_bubble, 16'h0000);
    check("pc", o_pc, 16'h0003);
    exec(14'h0F85, 8'hFF);
    check("wr", o_file_wr, 16'h8500);
    check("zero", o_zero, 16'h0000);
    check("bubble", o_bubble, 16'h0001);
    check("pc", o_pc, 16'h0005);
    // Word in the bubble cycle must not execute
    exec(14'h0A80, 8'h00);
    check("wr_we", o_file_wr.we, 16'h0000);
    check("pc", o_pc, 16'h0005);
    check("bubble", o_bubble, 16'h0000);
    idle();
  endtask

  task automatic t_rot();
    exec(14'h0D07, 8'hE6);
    check("w", o_w, 16'h00CC);
    check("carry", o_carry, 16'h0001);
    check("wr_we", o_file_wr.we, 16'h0000);
    exec(14'h0D88, 8'h01);
    check("wr", o_file_wr, 16'h8803);
    check("carry", o_carry, 16'h0000);
    check("pc", o_pc, 16'h0007);
    idle();
  endtask

  task automatic t_ret();
    exec(14'h0A00, 8'hFF);
    exec(14'h0D00, 8'h80);
    idle();
    push(13'h1234);
    push(13'h0567);
    i_call_push = 1'b0;
    // Don't-care bits 9..8 set on purpose
    exec(14'h375A, 8'h00);
    check("w", o_w, 16'h005A);
    check("pc", o_pc, 16'h0567);
    check("flags", {o_zero, o_carry}, 16'h0003);
    check("bubble", o_bubble, 16'h0001);
    exec(14'h0A80, 8'hFF);
    check("pc", o_pc, 16'h0567);
    check("wr_we", o_file_wr.we, 16'h0000);
    exec(14'h0008, 8'h00);
    check("pc", o_pc, 16'h1234);
    check("flags", {o_zero, o_carry}, 16'h0003);
    check("bubble", o_bubble, 16'h0001);
    exec(14'h3455, 8'h00);
    check("w", o_w, 16'h005A);
    check("pc", o_pc, 16'h1234);
    // Unlisted opcode only advances the program counter
    exec(14'h0B95, 8'hFF);
    check("pc", o_pc, 16'h1235);
    check("wr_we", o_file_wr.we, 16'h0000);
    check("w", o_w, 16'h005A);
    idle();
  endtask

  // ==========================================================================
  // Main sequence and hang guard
  initial begin
    n_fail = 0;
    samples_checked = 0;
    i_rst_b = 1'b0;
    i_instr_valid = 1'b0;
    i_instr = 14'h0000;
    i_file_data = 8'h00;
    i_call_push = 1'b0;
    i_call_addr = 13'h0000;
    repeat (10) @(negedge i_mclk);
    t_reset();
    i_rst_b = 1'b1;
    @(negedge i_mclk);
    t_inc();
    t_skip();
    t_rot();
    t_ret();
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge i_mclk);
    n_fail++;
    end_sim();
  end
endmodule
